// File: verilog/mds_pkg.sv
// ---------------------------------------------------------------------------
// shared constants of the modem dial sequencer
// ---------------------------------------------------------------------------
package mds_pkg;

  // system clock rate
  localparam int unsigned CLK_HZ          = 10_000_000;
  // response window after the default line, in milliseconds
  localparam int unsigned RESP_TIMEOUT_MS = 2000;
  // the same window in clock cycles (longest time, rounds down)
  localparam int unsigned RESP_CYCLES_DEF =
    RESP_TIMEOUT_MS * (CLK_HZ / 1000);

  // character codes used by the sequencer and the matcher
  localparam logic [7:0] CH_CR = 8'h0D;  // carriage return
  localparam logic [7:0] CH_LF = 8'h0A;  // line feed
  localparam logic [7:0] CH_O  = 8'h4F;  // letter O
  localparam logic [7:0] CH_K  = 8'h4B;  // letter K
  localparam logic [7:0] CH_A  = 8'h41;  // letter A

  // fixed text store: default line, attention prefix, dial prefix, return
  localparam int ROM_DEPTH = 16;
  localparam logic [7:0] ROM_TEXT [ROM_DEPTH] = '{
    8'h41, 8'h54, 8'h45, 8'h30, 8'h58, 8'h34, 8'h26, 8'h4B, 8'h30, 8'h0D,
    8'h41, 8'h54,
    8'h41, 8'h54, 8'h44,
    8'h0D
  };
  // index ranges of each fixed piece of text
  localparam logic [3:0] DEF_FIRST  = 4'h0;
  localparam logic [3:0] DEF_LAST   = 4'h9;
  localparam logic [3:0] AT_FIRST   = 4'hA;
  localparam logic [3:0] AT_LAST    = 4'hB;
  localparam logic [3:0] DIAL_FIRST = 4'hC;
  localparam logic [3:0] DIAL_LAST  = 4'hE;
  localparam logic [3:0] CR_IDX     = 4'hF;

  // user text source selection
  localparam logic SEL_INIT  = 1'b0;
  localparam logic SEL_PHONE = 1'b1;

  // sequencer states
  typedef enum logic [2:0] {
    MDS_IDLE, MDS_ROM, MDS_BODY, MDS_WAIT, MDS_READY, MDS_ABSENT
  } mds_state_type;

endpackage

// File: verilog/mds_ok_match.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// response matcher: finds a line holding exactly the word OK
// ---------------------------------------------------------------------------
module mds_ok_match
  import mds_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // received characters, same clock domain
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // listen only while high; low clears the line state
  input  wire logic       listen,
  // one-cycle pulse when an OK line ends
  output logic            ok_q
);

  logic [1:0] cnt_q, cnt_d;    // characters seen on this line, saturating
  logic       good_q, good_d;  // line so far still matches the word
  logic       ok_d;
  logic       is_term;         // current character ends a line

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    is_term = (rx_data == CH_CR) || (rx_data == CH_LF);
    cnt_d   = cnt_q;
    good_d  = good_q;
    ok_d    = 1'b0;
    if (!listen) begin
      // stale text from before the default line must not count
      cnt_d  = 2'd0;
      good_d = 1'b1;
    end else if (rx_valid && is_term) begin
      // empty lines fall through here, so leading terminators are skipped
      ok_d   = good_q && (cnt_q == 2'd2);
      cnt_d  = 2'd0;
      good_d = 1'b1;
    end else if (rx_valid) begin
      // compare by position, anything past two letters spoils the line
      unique case (cnt_q)
        2'd0:    good_d = good_q && (rx_data == CH_O);
        2'd1:    good_d = good_q && (rx_data == CH_K);
        default: good_d = 1'b0;
      endcase
      if (cnt_q != 2'd3) begin
        cnt_d = cnt_q + 2'd1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 2'd0;
      good_q <= 1'b1;
      ok_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      good_q <= good_d;
      ok_q   <= ok_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_ok_on_term;
    ok_q |-> $past(rx_valid && listen) &&
             ($past(rx_data) == CH_CR || $past(rx_data) == CH_LF);
  endproperty
  a_ok_on_term: assert property (p_ok_on_term)
    else $error("ok reported without a line terminator");

endmodule

// File: verilog/mds_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - session starts by sending the fixed default line
// - wait for OK as proof of a modem
// - after OK, send AT, user text, return
// - dial sends ATD, phone number, return
module mds_seq
  import mds_pkg::*;
#(
  parameter int unsigned RESP_CYCLES = RESP_CYCLES_DEF  // OK wait, cycles
)
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // session control from the monitor
  input  wire logic       start,      // pulse: begin a modem session
  input  wire logic       dial_req,   // pulse: dial, taken in ready state
  // user text stream (init text or phone number, picked by usr_sel_q)
  input  wire logic       usr_valid,
  input  wire logic [7:0] usr_data,
  input  wire logic       usr_last,
  output logic            usr_ready_q,
  output logic            usr_sel_q,
  // serial transmitter, same clock
  output logic            tx_valid_q,
  output logic [7:0]      tx_data_q,
  input  wire logic       tx_ready,
  // serial receiver, same clock
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  // status
  output logic            busy_q,       // a session step is in progress
  output logic            modem_ok_q,   // OK was received this session
  output logic            modem_absent_q, // no OK came in time
  output logic            ready_q,      // dial may be requested
  output logic            dial_done_q   // pulse: dial line fully sent
);

  // a zero window would leave the wait counter with nothing to count
  if (RESP_CYCLES < 1) begin : g_bad_resp
    $error("RESP_CYCLES must be at least one");
  end

  localparam int CW = $clog2(RESP_CYCLES + 1);

  mds_state_type   st_q, st_d;          // sequencer state
  logic [3:0]      idx_q, idx_d;        // fixed text read pointer
  logic [3:0]      end_q, end_d;        // last index of current piece
  logic [CW-1:0]   tmo_q, tmo_d;        // response wait counter
  logic            sel_d, urdy_d;
  logic            txv_d;
  logic [7:0]      txd_d;
  logic            ok_d, abs_d, done_d;
  logic            ok_pulse;            // OK line seen by the matcher
  logic            tx_free;             // transmit slot free this cycle

  // ---------------------------------------------------------------------------
  // response matcher
  // ---------------------------------------------------------------------------
  mds_ok_match u_match (
    .clock    (clock),
    .arst_n   (arst_n),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .listen   (st_q == MDS_WAIT),
    .ok_q     (ok_pulse)
  );

  // ---------------------------------------------------------------------------
  // sequencer next-state logic
  // ---------------------------------------------------------------------------
  // each character is held until the transmitter takes it; a new one is
  // loaded only on a cycle with no pending character, trading half the
  // throughput (two thirds for user text) for a very simple handshake (the line is far slower anyway)
  always_comb begin
    tx_free = !tx_valid_q;
    st_d    = st_q;
    idx_d   = idx_q;
    end_d   = end_q;
    tmo_d   = tmo_q;
    sel_d   = usr_sel_q;
    urdy_d  = usr_ready_q;
    txv_d   = tx_valid_q && !tx_ready;
    txd_d   = tx_data_q;
    ok_d    = modem_ok_q;
    abs_d   = modem_absent_q;
    done_d  = 1'b0;
    unique case (st_q)
      MDS_IDLE, MDS_READY, MDS_ABSENT: begin
        if (start) begin
          // fresh session always opens with the default line
          st_d  = MDS_ROM;
          idx_d = DEF_FIRST;
          end_d = DEF_LAST;
          ok_d  = 1'b0;
          abs_d = 1'b0;
        end else if (dial_req && st_q == MDS_READY) begin
          st_d  = MDS_ROM;
          idx_d = DIAL_FIRST;
          end_d = DIAL_LAST;
          sel_d = SEL_PHONE;
        end
      end
      MDS_ROM: begin
        if (tx_free) begin
          // load the next fixed character
          txv_d = 1'b1;
          txd_d = ROM_TEXT[idx_q];
        end else if (tx_ready) begin
          // character taken: advance or finish this piece
          idx_d = idx_q + 4'h1;
          if (idx_q == end_q) begin
            unique case (end_q)
              DEF_LAST: begin
                st_d  = MDS_WAIT;
                tmo_d = '0;
              end
              AT_LAST: begin
                st_d  = MDS_BODY;
                sel_d = SEL_INIT;
              end
              DIAL_LAST: begin
                st_d  = MDS_BODY;
                sel_d = SEL_PHONE;
              end
              default: begin
                // closing return of init or dial line
                st_d   = MDS_READY;
                done_d = (usr_sel_q == SEL_PHONE);
              end
            endcase
          end
        end
      end
      MDS_BODY: begin
        if (usr_ready_q && usr_valid) begin
          // pass one user character, return follows the last one
          urdy_d = 1'b0;
          txv_d  = 1'b1;
          txd_d  = usr_data;
          if (usr_last) begin
            st_d  = MDS_ROM;
            // the pending user char takes one slot ahead of the return,
            // so the return is loaded only after that char is taken
            idx_d = CR_IDX - 4'h1;
            end_d = CR_IDX;
          end
        end else if (tx_free && !usr_ready_q) begin
          urdy_d = 1'b1;
        end
      end
      MDS_WAIT: begin
        if (ok_pulse) begin
          // OK proves a working modem; the user line may now go out
          ok_d  = 1'b1;
          st_d  = MDS_ROM;
          idx_d = AT_FIRST;
          end_d = AT_LAST;
        end else if (tmo_q == CW'(RESP_CYCLES - 1)) begin
          // give up; nothing more is sent until a new start
          abs_d = 1'b1;
          st_d  = MDS_ABSENT;
        end else begin
          tmo_d = tmo_q + CW'(1);
        end
      end
      default: st_d = MDS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q           <= MDS_IDLE;
      idx_q          <= 4'h0;
      end_q          <= 4'h0;
      tmo_q          <= '0;
      usr_sel_q      <= SEL_INIT;
      usr_ready_q    <= 1'b0;
      tx_valid_q     <= 1'b0;
      tx_data_q      <= 8'h00;
      modem_ok_q     <= 1'b0;
      modem_absent_q <= 1'b0;
      busy_q         <= 1'b0;
      ready_q        <= 1'b0;
      dial_done_q    <= 1'b0;
    end else begin
      st_q           <= st_d;
      idx_q          <= idx_d;
      end_q          <= end_d;
      tmo_q          <= tmo_d;
      usr_sel_q      <= sel_d;
      usr_ready_q    <= urdy_d;
      tx_valid_q     <= txv_d;
      tx_data_q      <= txd_d;
      modem_ok_q     <= ok_d;
      modem_absent_q <= abs_d;
      busy_q         <= (st_d == MDS_ROM) || (st_d == MDS_BODY) ||
                        (st_d == MDS_WAIT);
      ready_q        <= (st_d == MDS_READY);
      dial_done_q    <= done_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_first_line;
    (start && st_q != MDS_ROM && st_q != MDS_BODY && st_q != MDS_WAIT)
      // the first character is loaded one cycle after the state change
      |=> ##1 (tx_valid_q && tx_data_q == CH_A && idx_q == DEF_FIRST);
  endproperty
  a_first_line: assert property (p_first_line)
    else $error("session did not open with the default line");

  property p_silent_wait;
    st_q == MDS_WAIT |-> !tx_valid_q && !usr_ready_q;
  endproperty
  a_silent_wait: assert property (p_silent_wait)
    else $error("output while waiting for the modem answer");

  property p_ok_then_at;
    (st_q == MDS_WAIT && ok_pulse)
      |=> modem_ok_q ##1 tx_valid_q && tx_data_q == CH_A;
  endproperty
  a_ok_then_at: assert property (p_ok_then_at)
    else $error("OK not followed by the attention prefix");

  property p_user_cr;
    (usr_ready_q && usr_valid && usr_last)
      |=> tx_valid_q ##[1:600] (tx_valid_q && tx_data_q == CH_CR);
  endproperty
  a_user_cr: assert property (p_user_cr)
    else $error("user text not closed by a return");

  property p_dial_start;
    (dial_req && st_q == MDS_READY && !start)
      |=> ##1 tx_valid_q && tx_data_q == CH_A && usr_sel_q == SEL_PHONE;
  endproperty
  a_dial_start: assert property (p_dial_start)
    else $error("dial request not answered by the dial prefix");

  property p_absent_silent;
    (modem_absent_q && !start) |-> !tx_valid_q && !usr_ready_q;
  endproperty
  a_absent_silent: assert property (p_absent_silent)
    else $error("output after the modem was reported absent");

  property p_timeout;
    (st_q == MDS_WAIT && !ok_pulse && tmo_q == CW'(RESP_CYCLES - 1))
      |=> modem_absent_q && !busy_q && $stable(tx_valid_q);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not report an absent modem");

endmodule

// File: sim/mds_modem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// behavioural modem on the far side of the serial port
// ---------------------------------------------------------------------------
module mds_modem_model
  import mds_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // characters from the transmitter
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // characters toward the receiver
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // behaviour: 0 silent, 1 answers OK, 2 answers a wrong word
  input  wire logic [1:0] mode,
  input  wire logic       slow
);
  logic [7:0] cmd_buf [$];  // command line being buffered
  logic [7:0] reply   [$];  // answer still to send
  logic [1:0] tick;         // stall pacing
  logic       pulse_dial;   // pulse dialling chosen by an executed line
  logic       smart_dial;   // extended results with line checks

  // one process: buffer, execute on return, answer
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      tick     <= 2'h0;
      pulse_dial <= 1'b0;
      smart_dial <= 1'b0;
      cmd_buf.delete();
      reply.delete();
    end else begin
      tick     <= tick + 2'h1;
      // stalls are transmitter pacing; the modem never holds off
      tx_ready <= slow ? (tick == 2'h2) : 1'b1;
      if (tx_valid && tx_ready) begin
        if (tx_data != CH_CR) begin
          cmd_buf.push_back(tx_data);
        end else begin
          // the return executes only a line opened by AT
          if (mode != 2'h0 && cmd_buf.size() >= 2 && cmd_buf[0] == CH_A
              && cmd_buf[1] == 8'h54) begin
            // settings carried by the executed line; tone until told
            for (int i = 2; i < cmd_buf.size(); i++) begin
              if (cmd_buf[i] == 8'h50) pulse_dial <= 1'b1;
              if (cmd_buf[i] == 8'h58 && i + 1 < cmd_buf.size()) begin
                if (cmd_buf[i+1] == 8'h34) smart_dial <= 1'b1;
                if (cmd_buf[i+1] == 8'h30) smart_dial <= 1'b0;
              end
            end
            reply.push_back(CH_CR);
            reply.push_back(CH_LF);
            if (mode == 2'h2) begin
              reply.push_back(8'h78);
            end
            reply.push_back(CH_O);
            reply.push_back(CH_K);
            reply.push_back(CH_CR);
            reply.push_back(CH_LF);
          end
          cmd_buf.delete();
        end
      end
      // one character every other cycle; idle data toggles, never stale
      if (reply.size() > 0 && !rx_valid) begin
        rx_valid <= 1'b1;
        rx_data  <= reply.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// bench for the modem dial sequencer
// ---------------------------------------------------------------------------
module tb;
  import mds_pkg::*;
  localparam int unsigned RESP = 50;  // short answer window for the run
  logic       clock, arst_n, start, dial_req, slow;
  logic       usr_valid, usr_last, usr_ready_q, usr_sel_q;
  logic [7:0] usr_data, tx_data_q, rx_data;
  logic       tx_valid_q, tx_ready, rx_valid, busy_q;
  logic       modem_ok_q, modem_absent_q, ready_q, dial_done_q;
  logic [1:0] mode;
  logic [7:0] sent [$];          // every character taken by the transmitter
  int         done_cnt, usr_idx, bad_count, check_count;
  string      init_txt  = "P";   // user text selecting pulse dialling
  string      phone_txt = "5551234";
  string      usr_txt;
  string      def_line  = "ATE0X4&K0\r";

  mds_seq #(.RESP_CYCLES(RESP)) uut (.clock(clock), .arst_n(arst_n),
    .start(start), .dial_req(dial_req), .usr_valid(usr_valid),
    .usr_data(usr_data), .usr_last(usr_last), .usr_ready_q(usr_ready_q),
    .usr_sel_q(usr_sel_q), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .busy_q(busy_q), .modem_ok_q(modem_ok_q),
    .modem_absent_q(modem_absent_q), .ready_q(ready_q),
    .dial_done_q(dial_done_q));
  mds_modem_model modem (.clock(clock), .arst_n(arst_n),
    .tx_valid(tx_valid_q), .tx_data(tx_data_q), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .mode(mode), .slow(slow));

  always #50 clock = ~clock;

  // record the transmitted stream and the dial completion pulses
  always @(posedge clock) begin
    if (tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
      sent.push_back(tx_data_q);
    end
    if (dial_done_q === 1'b1) begin
      done_cnt = done_cnt + 1;
    end
  end

  // user text source: init text or phone number as the sequencer asks
  always @(posedge clock) begin
    if (usr_ready_q === 1'b1 && usr_valid === 1'b1) begin
      usr_idx = usr_last ? 0 : usr_idx + 1;
    end
    #1;
    usr_txt = (usr_sel_q === SEL_PHONE) ? phone_txt : init_txt;
    usr_data = usr_txt[usr_idx];
    usr_last = (usr_idx == usr_txt.len() - 1);
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // whole transmitted stream against the expected text
  task automatic check_text(input string exp);
    check("length", sent.size(), exp.len());
    for (int i = 0; i < exp.len() && i < sent.size(); i++) begin
      check("char", sent[i], exp[i]);
    end
  endtask

  // one-cycle request pulse: start, or dial when dial is set
  task automatic go(input logic dial);
    @(posedge clock);
    #1;
    start    = !dial;
    dial_req = dial;
    @(posedge clock);
    #1;
    start    = 1'b0;
    dial_req = 1'b0;
  endtask

  // bounded wait until the sequencer rests in ready or absent
  task automatic settle(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #2;
      n++;
    end while (n < 3000 && modem_absent_q !== 1'b1
               && !(ready_q === 1'b1 && busy_q === 1'b0));
    if (n >= 3000) begin
      bad_count = bad_count + 1;
      $display("Error settle expected rest seen timeout");
      stop_test();
    end
  endtask

  task automatic t_session(input logic [1:0] m, input logic s,
                           input logic absent_exp);
    int n;
    sent.delete();
    mode = m;
    slow = s;
    go(1'b0);
    settle(n);
    check("absent", modem_absent_q, absent_exp);
    check("ok", modem_ok_q, !absent_exp);
    check("ready", ready_q, !absent_exp);
    check("busy", busy_q, 1'b0);
    if (absent_exp) begin
      check("window", n >= RESP && n < RESP + 80, 1'b1);
      check_text(def_line);
      // a dial request now must send nothing
      sent.delete();
      go(1'b1);
      repeat (30) @(posedge clock);
      check("quiet", sent.size(), 0);
    end else begin
      check_text({def_line, "AT", init_txt, "\r"});
    end
    $display("session test mode %0d done", m);
  endtask

  task automatic t_dial(input logic s);
    int n;
    sent.delete();
    done_cnt = 0;
    slow = s;
    go(1'b1);
    settle(n);
    check_text({"ATD", phone_txt, "\r"});
    // the done pulse rises with ready, so let the counter see it first
    repeat (2) @(posedge clock);
    #2;
    check("dial done", done_cnt, 1);
    check("ready", ready_q, 1'b1);
    check("pulse", modem.pulse_dial, 1'b1);
    check("smart", modem.smart_dial, 1'b1);
    $display("dial test done");
  endtask

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    start = 1'b0;
    dial_req = 1'b0;
    usr_valid = 1'b1;
    usr_data = 8'h00;
    usr_last = 1'b0;
    mode = 2'h1;
    slow = 1'b0;
    usr_idx = 0;
    done_cnt = 0;
    bad_count = 0;
    check_count = 0;
    repeat (6) @(posedge clock);
    #1;
    arst_n = 1'b1;
    check("rest", {busy_q, tx_valid_q, ready_q}, 3'h0);
    t_session(2'h1, 1'b1, 1'b0);
    t_dial(1'b1);
    t_session(2'h0, 1'b0, 1'b1);
    t_session(2'h2, 1'b0, 1'b1);
    t_session(2'h1, 1'b0, 1'b0);
    t_dial(1'b0);
    stop_test();
  end
endmodule
